// *** rtl/edge_level_detect.sv ***
`timescale 1ns/1ps
module edge_level_detect
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // synchronised input and setup
    input wire logic i_level,
    input wire logic_trig_pkg::mode_t i_mode,
    input wire logic i_first,
    // qualifying activity, combinational
    output logic o_hit
);
    import logic_trig_pkg::*;

    logic prev_reg;
    logic rise;
    logic fall;
    logic edge_ok;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            prev_reg <= 1'b0;
        else
            prev_reg <= i_level;
    end

    // edges need two samples inside the armed window
    assign rise = i_level & ~prev_reg;
    assign fall = ~i_level & prev_reg;
    assign edge_ok = ~i_first;

    // undefined codes fall to the disabled branch
    always_comb
    begin
        case (i_mode)
            MODE_RISING_EDGE: o_hit = edge_ok & rise;
            MODE_FALLING_EDGE: o_hit = edge_ok & fall;
            MODE_ANY_EDGE: o_hit = edge_ok & (rise | fall);
            MODE_HIGH_LEVEL: o_hit = i_level;
            MODE_LOW_LEVEL: o_hit = ~i_level;
            MODE_DISABLED: o_hit = 1'b0;
            default: o_hit = 1'b0;
        endcase
    end

endmodule : edge_level_detect

// *** rtl/input_sync.sv ***
`timescale 1ns/1ps
module input_sync
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pins and synchronised copy
    input wire logic [logic_trig_pkg::NUM_INPUTS-1:0] i_async,
    output logic [logic_trig_pkg::NUM_INPUTS-1:0] o_sync
);
    import logic_trig_pkg::*;

    logic [NUM_INPUTS-1:0] meta_reg;
    logic [NUM_INPUTS-1:0] sync_reg;

    // first stage feeds the second stage only
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : input_sync

// *** rtl/logic_trig_pkg.sv ***
package logic_trig_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int NUM_INPUTS = 4;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int MODE_W = 5;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
    typedef logic [MODE_W-1:0] mode_t;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam addr_t OFS_MODE [NUM_INPUTS] = '{
        20'h09e3f, 20'h09e40, 20'h09e41, 20'h09e47
    };
    localparam addr_t OFS_TERM [NUM_INPUTS] = '{
        20'h92824, 20'h92825, 20'h92826, 20'h92827
    };
    localparam addr_t OFS_OR_MASK = 20'h09dda;
    localparam addr_t OFS_STATUS = 20'h09e50;

    // ----------------------------------------------------------------
    // mode codes
    // ----------------------------------------------------------------
    localparam mode_t MODE_DISABLED = 5'h00;
    localparam mode_t MODE_RISING_EDGE = 5'h01;
    localparam mode_t MODE_FALLING_EDGE = 5'h02;
    localparam mode_t MODE_ANY_EDGE = 5'h04;
    localparam mode_t MODE_HIGH_LEVEL = 5'h08;
    localparam mode_t MODE_LOW_LEVEL = 5'h10;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int OR_MASK_BASE = 2;
    localparam int TERM_BIT = 0;
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_FIRED_BIT = 1;
    localparam int STAT_SRC_LSB = 8;
    localparam mode_t MODE_RESET = 5'h00;
    localparam data_t OR_MASK_RESET = 32'h0000_0000;
    localparam logic TERM_RESET = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_FIRED = 2'b10
    } arm_state_e;

endpackage : logic_trig_pkg

// *** rtl/logic_trigger_top.sv ***
// What this block does
// - rising-edge mode triggers on first rise
// - falling-edge mode triggers on first fall
// - any-edge mode triggers on first transition
// - high-level mode triggers on high sample
// - low-level mode triggers on low sample
// - level already present at start triggers immediately
// - after trigger, ignore inputs until re-armed
// - termination bit one 50 Ohm, zero high-Z
// - mode zero never contributes a trigger
// - input counts only when OR mask enabled
`timescale 1ns/1ps
module logic_trigger_top
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic_trig_pkg::addr_t I_ADDR,
    input wire logic_trig_pkg::data_t I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic_trig_pkg::data_t O_RDATA,
    // logic input pins
    input wire logic [logic_trig_pkg::NUM_INPUTS-1:0] I_LOGIC_IN,
    // termination select per pin
    output logic [logic_trig_pkg::NUM_INPUTS-1:0] O_TERM_50,
    // acquisition sequencer
    input wire logic I_ARM,
    output logic O_TRIG,
    output logic [logic_trig_pkg::NUM_INPUTS-1:0] O_TRIG_SRC,
    output logic O_ARMED
);
    import logic_trig_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    mode_t mode_reg [NUM_INPUTS];
    mode_t mode_next [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] term_reg;
    logic [NUM_INPUTS-1:0] term_next;
    data_t or_mask_reg;
    data_t or_mask_next;
    data_t rdata_reg;
    data_t rdata_next;
    arm_state_e state_reg;
    arm_state_e state_next;
    logic first_reg;
    logic first_next;
    logic trig_reg;
    logic trig_next;
    logic [NUM_INPUTS-1:0] src_reg;
    logic [NUM_INPUTS-1:0] src_next;
    // registered copy of the armed decode so the pin comes from a flop
    logic armed_reg;

    logic [NUM_INPUTS-1:0] level_sync;
    logic [NUM_INPUTS-1:0] det_hit;
    logic [NUM_INPUTS-1:0] masked_hit;
    logic [NUM_INPUTS-1:0] wr_mode;
    logic [NUM_INPUTS-1:0] wr_term;
    data_t rd_part [NUM_INPUTS];
    data_t rd_inputs;
    data_t status_word;
    logic wr_or_mask;
    logic rd_or_mask;
    logic rd_status;
    logic armed;
    logic fire;

    function automatic logic reg_hit(input addr_t a, input addr_t ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    input_sync u_sync
    (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_async(I_LOGIC_IN),
        .o_sync(level_sync)
    );

    // ----------------------------------------------------------------
    // per-input detection and decode
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++)
        begin : g_in
            edge_level_detect u_det
            (
                .i_clk(I_CLK),
                .i_rst(I_SYS_RST),
                .i_level(level_sync[gi]),
                .i_mode(mode_reg[gi]),
                .i_first(first_reg),
                .o_hit(det_hit[gi])
            );

            // mask gate keeps a configured but unselected pin silent
            assign masked_hit[gi] = det_hit[gi] & or_mask_reg[OR_MASK_BASE + gi];

            assign wr_mode[gi] = I_WR & reg_hit(I_ADDR, OFS_MODE[gi]);
            assign wr_term[gi] = I_WR & reg_hit(I_ADDR, OFS_TERM[gi]);

            assign mode_next[gi] = wr_mode[gi] ? I_WDATA[MODE_W-1:0] : mode_reg[gi];
            assign term_next[gi] = wr_term[gi] ? I_WDATA[TERM_BIT] : term_reg[gi];

            assign rd_part[gi] =
                (reg_hit(I_ADDR, OFS_MODE[gi]) ?
                    {{(DATA_W-MODE_W){1'b0}}, mode_reg[gi]} : '0) |
                (reg_hit(I_ADDR, OFS_TERM[gi]) ?
                    {{(DATA_W-1){1'b0}}, term_reg[gi]} : '0);
        end
    endgenerate

    // ----------------------------------------------------------------
    // shared registers and read mux
    // ----------------------------------------------------------------
    assign wr_or_mask = I_WR & reg_hit(I_ADDR, OFS_OR_MASK);
    assign rd_or_mask = reg_hit(I_ADDR, OFS_OR_MASK);
    assign rd_status = reg_hit(I_ADDR, OFS_STATUS);
    assign or_mask_next = wr_or_mask ? I_WDATA : or_mask_reg;

    always_comb
    begin
        rd_inputs = '0;
        for (int k = 0; k < NUM_INPUTS; k++)
            rd_inputs = rd_inputs | rd_part[k];
    end

    always_comb
    begin
        status_word = '0;
        status_word[STAT_ARMED_BIT] = (state_reg == ST_ARMED);
        status_word[STAT_FIRED_BIT] = (state_reg == ST_FIRED);
        status_word[STAT_SRC_LSB +: NUM_INPUTS] = src_reg;
    end

    // data only in the cycle after the strobe; unmapped reads give zero
    assign rdata_next = !I_RD ? '0 :
                        rd_status ? status_word :
                        rd_or_mask ? or_mask_reg :
                        rd_inputs;

    // ----------------------------------------------------------------
    // arm sequencing
    // ----------------------------------------------------------------
    assign armed = (state_reg == ST_ARMED);
    assign fire = armed & (|masked_hit);

    always_comb
    begin
        state_next = state_reg;
        first_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (I_ARM)
                begin
                    state_next = ST_ARMED;
                    first_next = 1'b1;
                end
            end
            ST_ARMED:
            begin
                // a late arm pulse while armed changes nothing
                if (fire)
                    state_next = ST_FIRED;
            end
            ST_FIRED:
            begin
                // stays deaf until the sequencer re-arms after the record
                if (I_ARM)
                begin
                    state_next = ST_ARMED;
                    first_next = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // one pulse per armed window, then the state leaves ST_ARMED
    assign trig_next = fire;
    assign src_next = fire ? masked_hit :
                      (I_ARM && !armed) ? '0 : src_reg;

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
                mode_reg[k] <= MODE_RESET;
            term_reg <= {NUM_INPUTS{TERM_RESET}};
            or_mask_reg <= OR_MASK_RESET;
        end
        else
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
                mode_reg[k] <= mode_next[k];
            term_reg <= term_next;
            or_mask_reg <= or_mask_next;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_reg <= ST_IDLE;
            first_reg <= 1'b0;
            trig_reg <= 1'b0;
            src_reg <= '0;
            rdata_reg <= '0;
            armed_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            first_reg <= first_next;
            trig_reg <= trig_next;
            src_reg <= src_next;
            rdata_reg <= rdata_next;
            armed_reg <= (state_next == ST_ARMED);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign O_RDATA = rdata_reg;
    assign O_TERM_50 = term_reg;
    assign O_TRIG = trig_reg;
    assign O_TRIG_SRC = src_reg;
    assign O_ARMED = armed_reg;

endmodule : logic_trigger_top

// *** testbench/logic_trigger_assertions.sv ***
`timescale 1ns/1ps
module logic_trigger_assertions
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic_trig_pkg::addr_t I_ADDR,
    input wire logic_trig_pkg::data_t I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic_trig_pkg::data_t O_RDATA,
    // pins and sequencer
    input wire logic [logic_trig_pkg::NUM_INPUTS-1:0] O_TERM_50,
    input wire logic I_ARM,
    input wire logic O_TRIG,
    input wire logic [logic_trig_pkg::NUM_INPUTS-1:0] O_TRIG_SRC,
    input wire logic O_ARMED
);
    import logic_trig_pkg::*;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    // ----------------------------------------------------------------
    // arming, firing, termination write and read data
    // ----------------------------------------------------------------
    sequence s_arm;
        I_ARM && !O_ARMED;
    endsequence
    sequence s_quiet;
        !I_ARM ##1 !O_TRIG;
    endsequence
    a_arm_sets: assert property (s_arm |=> O_ARMED && O_TRIG_SRC == '0)
        else $error("arm did not set armed state");
    a_armed_holds: assert property (O_ARMED |=> O_ARMED || O_TRIG)
        else $error("armed state lost without trigger");
    a_trig_pulse: assert property (O_TRIG |=> !O_TRIG)
        else $error("trigger longer than one cycle");
    a_trig_armed: assert property (O_TRIG |-> $past(O_ARMED) && !O_ARMED)
        else $error("trigger outside armed window");
    a_trig_source: assert property (O_TRIG |-> O_TRIG_SRC != '0)
        else $error("trigger without source");
    a_src_holds: assert property (s_quiet |-> $stable(O_TRIG_SRC))
        else $error("source changed without trigger");
    a_term_write: assert property (I_WR && I_ADDR == OFS_TERM[0] |=>
        O_TERM_50[0] == $past(I_WDATA[0])) else $error("termination write lost");
    a_read_zero: assert property (!I_RD |=> O_RDATA == '0)
        else $error("read data outside read cycle");
endmodule : logic_trigger_assertions

bind logic_trigger_top logic_trigger_assertions logic_trigger_assertions_i (.I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_TERM_50(O_TERM_50), .I_ARM(I_ARM), .O_TRIG(O_TRIG),
    .O_TRIG_SRC(O_TRIG_SRC), .O_ARMED(O_ARMED));

// *** testbench/tb_logic_trigger_top.sv ***
`timescale 1ns/1ps
module tb_logic_trigger_top;
    import logic_trig_pkg::*;
    typedef struct {mode_t mode; int idx; logic lv0; logic lv1; logic fire; data_t mask;} row_s;
    logic clk = 1'h0;
    logic rst = 1'h1;
    addr_t addr = '0;
    data_t wdata = '0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic arm = 1'h0;
    logic [3:0] req = 4'h0;
    data_t rdata;
    logic [3:0] pins, term, src;
    logic trig, armed;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    row_s rows [13] = '{
        '{MODE_RISING_EDGE, 0, 1'h0, 1'h1, 1'h1, 32'h3c}, '{MODE_RISING_EDGE, 1, 1'h1, 1'h0, 1'h0, 32'h3c},
        '{MODE_FALLING_EDGE, 2, 1'h1, 1'h0, 1'h1, 32'h3c}, '{MODE_FALLING_EDGE, 3, 1'h0, 1'h1, 1'h0, 32'h3c},
        '{MODE_ANY_EDGE, 0, 1'h1, 1'h0, 1'h1, 32'h3c}, '{MODE_ANY_EDGE, 1, 1'h0, 1'h1, 1'h1, 32'h3c},
        '{MODE_HIGH_LEVEL, 2, 1'h0, 1'h1, 1'h1, 32'h3c}, '{MODE_HIGH_LEVEL, 3, 1'h1, 1'h1, 1'h1, 32'h3c},
        '{MODE_LOW_LEVEL, 0, 1'h1, 1'h0, 1'h1, 32'h3c}, '{MODE_LOW_LEVEL, 1, 1'h0, 1'h0, 1'h1, 32'h3c},
        '{MODE_DISABLED, 2, 1'h0, 1'h1, 1'h0, 32'h3c}, '{5'h03, 3, 1'h0, 1'h1, 1'h0, 32'h3c},
        '{MODE_RISING_EDGE, 0, 1'h0, 1'h1, 1'h0, 32'h38}};

    always #12.5 clk = ~clk;

    ttl_source ttl_source_i (.i_req(req), .o_pin(pins));
    logic_trigger_top logic_trigger_top_i (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_LOGIC_IN(pins),
        .O_TERM_50(term), .I_ARM(arm), .O_TRIG(trig), .O_TRIG_SRC(src), .O_ARMED(armed));

    // ----------------------------------------------------------------
    // bench tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task wr_reg(input addr_t a, input data_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    task rd_reg(input addr_t a, input data_t exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 check(rdata, exp);
    endtask : rd_reg
    task do_reset;
        rst <= 1'h1;
        cyc(5);
        rst <= 1'h0;
    endtask : do_reset
    task do_arm;
        @(posedge clk);
        arm <= 1'h1;
        @(posedge clk);
        arm <= 1'h0;
        #1;
    endtask : do_arm
    // bounded wait: a missing trigger shows up in the compare after it
    task wait_trig(input int lim);
        n = 0;
        while (trig !== 1'h1 && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_trig

    initial
    begin
        cyc(20000);
        n_mismatch++;
        stop_test;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        foreach (rows[r])
        begin
            do_reset;
            req <= {4{rows[r].lv0}};
            cyc(3);
            wr_reg(OFS_OR_MASK, rows[r].mask);
            wr_reg(OFS_MODE[rows[r].idx], 32'(rows[r].mode));
            do_arm;
            check(armed, 1'h1);
            fork
                begin
                    cyc(2);
                    req[rows[r].idx] <= rows[r].lv1;
                end
                wait_trig(12);
            join
            check({trig, src}, {rows[r].fire, rows[r].fire ? 4'(1 << rows[r].idx) : 4'h0});
        end
        // level present at arm: two inputs fire in one pulse, then stay quiet
        do_reset;
        req <= 4'h3;
        cyc(3);
        wr_reg(OFS_OR_MASK, 32'h3c);
        wr_reg(OFS_MODE[0], 32'h08);
        wr_reg(OFS_MODE[1], 32'h08);
        do_arm;
        cyc(1);
        #1 check({trig, src}, {1'h1, 4'h3});
        cyc(1);
        #1 check(trig, 1'h0);
        wait_trig(8);
        check(n, 8);
        do_arm;
        cyc(1);
        #1 check({trig, armed}, {1'h1, 1'h0});
        rd_reg(OFS_STATUS, 32'h302);
        rd_reg(OFS_OR_MASK, 32'h3c);
        // registers: reset values, termination, field masking, unmapped
        do_reset;
        for (int k = 0; k < 4; k++)
        begin
            rd_reg(OFS_TERM[k], 32'h0);
            rd_reg(OFS_MODE[k], 32'h0);
            wr_reg(OFS_TERM[k], 32'h1);
        end
        #1 check(term, 4'hf);
        wr_reg(OFS_TERM[1], 32'hffff_fffe);
        wr_reg(20'h00001, 32'h0);
        #1 check(term, 4'hd);
        rd_reg(OFS_TERM[2], 32'h1);
        wr_reg(OFS_MODE[3], 32'hffff_ffff);
        rd_reg(OFS_MODE[3], 32'h1f);
        rd_reg(20'h00000, 32'h0);
        stop_test;
    end
endmodule : tb_logic_trigger_top

// *** testbench/ttl_source.sv ***
`timescale 1ns/1ps
module ttl_source
(
    // levels wanted by the bench
    input wire logic [logic_trig_pkg::NUM_INPUTS-1:0] i_req,
    // driven pins
    output logic [logic_trig_pkg::NUM_INPUTS-1:0] o_pin
);
    // a fixed skew keeps pin changes off the clock edge, as a foreign source
    assign #7 o_pin = i_req;
endmodule : ttl_source
